// File: verilog/dot_product_accumulate_unit.sv
// Four-accumulator dot-product accumulate unit, top level.
`timescale 1ns/10ps
`include "dot_acc_params.svh"
// Operation
// RULE1 - Left byte pair: upper two bytes multiplied
// RULE2 - Right byte pair: low bytes multiplied unsigned
// RULE3 - Byte products zero-extended, added to accumulator
// RULE4 - Two-bit select picks accumulator zero to three
// RULE5 - Right-byte op leaves overflow flags unchanged
// RULE6 - Integer cross and subtract keep overflow flags
// RULE7 - Cross: upper-by-lower, lower-by-upper signed products
// RULE8 - Cross sum sign-extended, added to accumulator
// RULE9 - Subtract: like halves multiplied as signed
// RULE10 - Straight sum sign-extended, subtracted from accumulator
// RULE11 - No data-dependent exceptions ever raised
// RULE12 - Decode right-byte by sub-op 00111, classes
// RULE13 - Decode cross by sub-op 01000, class
// RULE14 - Reserved or disabled exceptions when extension unusable
// RULE15 - Results wrap modulo two to sixty-four
// RULE16 - Decode subtract by sub-op 00001, select bits
module dot_product_accumulate_unit (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic issueValid,
  input dot_acc_pkg::issue_s issue,
  input wire logic extPresent,
  input wire logic extEnabled,
  input wire logic [3:0] ovfFlagsIn,
  output logic [3:0] ovfFlags,
  output logic reservedExc,
  output logic disabledExc,
  output logic dataExc,
  output logic accepted,
  output logic [31:0] upperWordHalf,
  output logic [31:0] bottomWordHalf,
  input wire logic [1:0] readSel
);
  import dot_acc_pkg::*;

  // Timing overview of the unit.
  // The pipeline presents one instruction per cycle on the issue port.
  // An instruction is taken at the rising edge at which it is valid,
  // decodes to one of the four operations, and the extension is both
  // present and enabled.
  // The selected accumulator pair is written at that same edge.
  // The read port is registered, so a value written at edge N shows on
  // the two read halves one cycle after the read select names it.
  // Exception pulses are registered too and stand for one cycle per refused instruction.
  // Back-to-back instructions to one accumulator are safe: the adder reads
  // the flip-flop contents, which already hold the previous result.
  //
  // Datapath overview.
  // The byte operations form two unsigned 16-bit products and add them,
  // zero-extended, to the accumulator.
  // The halfword operations form two signed 32-bit products, add them in
  // 33 bits so that no carry is lost, and sign-extend the sum to 64 bits.
  // The subtract operation takes that sum away from the accumulator.
  // All 64-bit arithmetic wraps; there is no saturation in this group,
  // which is also why the overflow sticky field never changes here.
  //
  // Limitations a user must know.
  // The zero field in bits 15..13 is not checked by the decoder, so an
  // encoding with those bits set still executes.
  // The overflow field is only mirrored from the control register; the
  // fractional variants that would set it are not part of this unit.
  // A reserved-instruction trap wins over a disabled trap, since an absent
  // extension cannot meaningfully be turned off.
  //
  // Trade-off: the multiply and add chain is a single combinational stage.
  // At 125 MHz this keeps the accumulate latency at one cycle, at the cost
  // of a long path from the issue operands to the accumulator flip-flops.

  // Decoded view of the instruction on the issue port.
  decoded_s decoded;
  // Dot-product term and direction from the datapath.
  logic [63:0] dotSum;
  logic subtract;
  // Accumulator pairs, upper half in 63..32, lower half in 31..0.
  logic [63:0] accumulator [4];
  // Overflow sticky flags, owned by this unit on behalf of the control register.
  logic [3:0] ovfSticky;
  // Registered read data and exception pulses.
  logic [63:0] readData;
  logic reservedPulse;
  logic disabledPulse;

  dot_acc_decoder decoderInst (
    .instrWord(issue.instrWord),
    .decoded(decoded)
  );

  dot_acc_products productsInst (
    .op(decoded.op),
    .sourceOne(issue.sourceOne),
    .sourceTwo(issue.sourceTwo),
    .dotSum(dotSum),
    .subtract(subtract)
  );

  // An instruction of the group is present on the port.
  wire isDotOp = issueValid && (decoded.op != OP_NONE);
  // Absent extension wins over a disabled one, as the reserved trap is more basic.
  wire reservedHit = isDotOp && !extPresent; // RULE14
  wire disabledHit = isDotOp && extPresent && !extEnabled; // RULE14
  // Only an allowed instruction updates an accumulator.
  wire doWrite = isDotOp && extPresent && extEnabled;
  // Selected accumulator contents.
  wire [63:0] selAcc = accumulator[decoded.sel]; // RULE4
  // Plain 64-bit add or subtract wraps by construction; no saturation.
  wire [63:0] next_acc = subtract ? (selAcc - dotSum) : (selAcc + dotSum); // RULE15

  // One write port per accumulator, chosen by the select field.
  genvar idx;
  generate
    for (idx = 0; idx < 4; idx++) begin : g_acc
      wire hitThis = doWrite && (decoded.sel == 2'(idx)); // RULE4
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          accumulator[idx] <= `ACC_RESET;
        end else if (hitThis) begin
          accumulator[idx] <= next_acc; // RULE3 RULE8 RULE10 RULE15
        end
      end
    end
  endgenerate

  // Overflow flags follow the control register copy; these ops never set them.
  // The integer and byte ops here have no saturation path, so the field passes
  // through untouched even while one of them writes.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovfSticky <= `OVF_RESET;
    end else begin
      ovfSticky <= ovfFlagsIn; // RULE5 RULE6
    end
  end

  // Read port and exception pulses, registered for clean outputs.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      readData <= `ACC_RESET;
      reservedPulse <= 1'b0;
      disabledPulse <= 1'b0;
    end else begin
      readData <= accumulator[readSel];
      reservedPulse <= reservedHit;
      disabledPulse <= disabledHit;
    end
  end

  assign ovfFlags = ovfSticky;
  assign reservedExc = reservedPulse;
  assign disabledExc = disabledPulse;
  // Data values never produce a trap.
  assign dataExc = 1'b0; // RULE11
  assign accepted = doWrite;
  // Upper word from bits 63..32, lower from 31..0.
  assign upperWordHalf = readData[63:32]; // RULE15
  assign bottomWordHalf = readData[31:0]; // RULE15

  // Helper: previous-cycle view for the checks.
  logic pastWrite;
  logic [1:0] pastSel;
  logic [63:0] pastNext;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pastWrite <= 1'b0;
      pastSel <= 2'h0;
      pastNext <= `ACC_RESET;
    end else begin
      pastWrite <= doWrite;
      pastSel <= decoded.sel;
      pastNext <= next_acc;
    end
  end

  // All checks run on the core clock and are silenced while reset is high.
  // The helper registers above give the two accumulator write checks a clean view of the cycle
  // before, without applying $past to an array element through a variable index.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // A cycle without a write must leave the addressed pair as it was.
  // This guards against refused or foreign encodings leaking into storage.
  no_stray_write_a: assert property (!doWrite |=> accumulator[pastSel] == $past(selAcc)) // RULE14
    else $error("Accumulator changed without an accepted op.");

  // The cross products pair the upper half of one source with the lower
  // half of the other; the expected sum is formed here at full width.
  cross_products_a: assert property ((decoded.op == OP_CROSS) |->
      dotSum == 64'($signed(issue.sourceOne[31:16]) * $signed(issue.sourceTwo[15:0])) +
                64'($signed(issue.sourceOne[15:0]) * $signed(issue.sourceTwo[31:16]))) // RULE7
    else $error("Cross dot sum wrong.");

  // The straight products pair like halves of the two sources.
  straight_products_a: assert property ((decoded.op == OP_SUBTRACT) |->
      dotSum == 64'($signed(issue.sourceOne[31:16]) * $signed(issue.sourceTwo[31:16])) +
                64'($signed(issue.sourceOne[15:0]) * $signed(issue.sourceTwo[15:0]))) // RULE9
    else $error("Straight dot sum wrong.");

  acc_write_lands_a: assert property (pastWrite |-> accumulator[pastSel] == pastNext) // RULE4
    else $error("Accumulator write did not land in selected pair.");
  left_byte_sum_a: assert property ((decoded.op == OP_LEFT_BYTE) |->
      dotSum == 64'(issue.sourceOne[31:24] * issue.sourceTwo[31:24]) +
                64'(issue.sourceOne[23:16] * issue.sourceTwo[23:16])) // RULE1
    else $error("Left byte dot sum wrong.");
  right_byte_sum_a: assert property ((decoded.op == OP_RIGHT_BYTE) |->
      dotSum == 64'(issue.sourceOne[15:8] * issue.sourceTwo[15:8]) +
                64'(issue.sourceOne[7:0] * issue.sourceTwo[7:0])) // RULE2
    else $error("Right byte dot sum wrong.");
  byte_zero_ext_a: assert property ((decoded.op inside {OP_LEFT_BYTE, OP_RIGHT_BYTE}) |->
      dotSum[63:17] == 47'h0) // RULE3
    else $error("Byte dot sum not zero-extended.");
  ovf_unchanged_a: assert property (doWrite |=> ovfFlags == $past(ovfFlagsIn)) // RULE5 RULE6
    else $error("Overflow flags changed by dot op.");
  cross_sign_ext_a: assert property ((decoded.op == OP_CROSS) |->
      (dotSum[63:32] == {32{dotSum[32]}})) // RULE8
    else $error("Cross sum not sign-extended.");
  sub_direction_a: assert property (doWrite && subtract |->
      next_acc + dotSum == selAcc) // RULE10
    else $error("Subtract result wrong.");
  no_data_trap_a: assert property (dataExc == 1'b0) // RULE11
    else $error("Data-dependent exception raised.");
  right_decode_a: assert property (issue.instrWord[31:26] == `EXT_MAJOR_OPCODE &&
      issue.instrWord[5:0] == `DOT_FUNC_CLASS && issue.instrWord[10:6] == `SUBOP_RIGHT_BYTE
      |-> decoded.op == OP_RIGHT_BYTE) // RULE12
    else $error("Right byte decode missed.");
  cross_decode_a: assert property (issue.instrWord[31:26] == `EXT_MAJOR_OPCODE &&
      issue.instrWord[5:0] == `DOT_FUNC_CLASS && issue.instrWord[10:6] == `SUBOP_CROSS
      |-> decoded.op == OP_CROSS) // RULE13
    else $error("Cross decode missed.");
  sub_decode_a: assert property (issue.instrWord[31:26] == `EXT_MAJOR_OPCODE &&
      issue.instrWord[5:0] == `DOT_FUNC_CLASS && issue.instrWord[10:6] == `SUBOP_SUBTRACT
      |-> decoded.op == OP_SUBTRACT) // RULE16
    else $error("Subtract decode missed.");
  reserved_trap_a: assert property (reservedHit |=> reservedExc && !disabledExc) // RULE14
    else $error("Reserved trap missing.");
  disabled_trap_a: assert property (disabledHit |=> disabledExc ##1 !disabledExc || disabledHit) // RULE14
    else $error("Disabled trap missing.");

  cover_cross_c: cover property (doWrite && decoded.op == OP_CROSS);
  cover_sub_c: cover property (doWrite && decoded.op == OP_SUBTRACT);
  cover_wrap_c: cover property (doWrite && !subtract && next_acc < selAcc);
  cover_acc3_c: cover property (doWrite && decoded.sel == 2'h3);
  // A refused instruction must also be seen at least once.
  cover_refuse_c: cover property (reservedHit || disabledHit);
endmodule : dot_product_accumulate_unit

// File: verilog/dot_acc_params.svh
// Constant definitions for the dot-product accumulate unit.
`ifndef DOT_ACC_PARAMS_SVH
`define DOT_ACC_PARAMS_SVH
`define MAJOR_MSB 31
`define MAJOR_LSB 26
`define SUBOP_MSB 10
`define SUBOP_LSB 6
`define FUNC_MSB 5
`define FUNC_LSB 0
`define SEL_MSB 12
`define SEL_LSB 11
`define ZERO_MSB 15
`define ZERO_LSB 13
`define EXT_MAJOR_OPCODE 6'h1F
`define DOT_FUNC_CLASS 6'h30
`define SUBOP_LEFT_BYTE 5'h03
`define SUBOP_RIGHT_BYTE 5'h07
`define SUBOP_CROSS 5'h08
`define SUBOP_SUBTRACT 5'h01
`define ACC_RESET 64'h0000000000000000
`define OVF_RESET 4'h0
`endif

// File: verilog/dot_acc_pkg.sv
// Types shared by the dot-product accumulate unit.
package dot_acc_pkg;
  // Operation chosen by the decoder.
  typedef enum logic [2:0] {
    OP_NONE,
    OP_LEFT_BYTE,
    OP_RIGHT_BYTE,
    OP_CROSS,
    OP_SUBTRACT
  } dot_op_e;
  // One issued instruction from the pipeline.
  typedef struct packed {
    logic [31:0] instrWord;
    logic [31:0] sourceOne;
    logic [31:0] sourceTwo;
  } issue_s;
  // Decoder result.
  typedef struct packed {
    dot_op_e op;
    logic [1:0] sel;
  } decoded_s;
endpackage : dot_acc_pkg

// File: verilog/dot_acc_decoder.sv
// Instruction decoder for the dot-product accumulate unit.
`timescale 1ns/10ps
`include "dot_acc_params.svh"
module dot_acc_decoder (
  input wire logic [31:0] instrWord,
  output dot_acc_pkg::decoded_s decoded
);
  import dot_acc_pkg::*;
  // Field slices of the instruction word.
  wire [5:0] majorField = instrWord[`MAJOR_MSB:`MAJOR_LSB];
  wire [4:0] subField = instrWord[`SUBOP_MSB:`SUBOP_LSB];
  wire [5:0] funcField = instrWord[`FUNC_MSB:`FUNC_LSB];
  // Both class fields must match before any sub-operation counts.
  wire classHit = (majorField == `EXT_MAJOR_OPCODE) && (funcField == `DOT_FUNC_CLASS);
  wire leftHit = classHit && (subField == `SUBOP_LEFT_BYTE);
  wire rightHit = classHit && (subField == `SUBOP_RIGHT_BYTE); // RULE12
  wire crossHit = classHit && (subField == `SUBOP_CROSS); // RULE13
  wire subHit = classHit && (subField == `SUBOP_SUBTRACT); // RULE16
  // Priority select; the hits are mutually exclusive anyway.
  assign decoded.op = leftHit ? OP_LEFT_BYTE :
                      rightHit ? OP_RIGHT_BYTE :
                      crossHit ? OP_CROSS :
                      subHit ? OP_SUBTRACT : OP_NONE;
  assign decoded.sel = instrWord[`SEL_MSB:`SEL_LSB]; // RULE4 RULE16
endmodule : dot_acc_decoder

// File: verilog/dot_acc_products.sv
// Pairwise product and dot-sum datapath, purely combinational.
`timescale 1ns/10ps
module dot_acc_products (
  input dot_acc_pkg::dot_op_e op,
  input wire logic [31:0] sourceOne,
  input wire logic [31:0] sourceTwo,
  output logic [63:0] dotSum,
  output logic subtract
);
  import dot_acc_pkg::*;
  // Unsigned byte products, left pair and right pair.
  wire [15:0] leftUpProd = sourceOne[31:24] * sourceTwo[31:24]; // RULE1
  wire [15:0] leftDnProd = sourceOne[23:16] * sourceTwo[23:16]; // RULE1
  wire [15:0] rightUpProd = sourceOne[15:8] * sourceTwo[15:8]; // RULE2
  wire [15:0] rightDnProd = sourceOne[7:0] * sourceTwo[7:0]; // RULE2
  // Signed halfwords of each source.
  wire signed [15:0] oneUp = sourceOne[31:16];
  wire signed [15:0] oneDn = sourceOne[15:0];
  wire signed [15:0] twoUp = sourceTwo[31:16];
  wire signed [15:0] twoDn = sourceTwo[15:0];
  // Cross products pair opposite halves; straight products pair like halves.
  wire signed [31:0] crossB = oneUp * twoDn; // RULE7
  wire signed [31:0] crossA = oneDn * twoUp; // RULE7
  wire signed [31:0] straightB = oneUp * twoUp; // RULE9
  wire signed [31:0] straightA = oneDn * twoDn; // RULE9
  // 33-bit signed sums cannot overflow, so no saturation exists here.
  wire signed [32:0] crossSum = 33'(crossB) + 33'(crossA); // RULE8
  wire signed [32:0] straightSum = 33'(straightB) + 33'(straightA); // RULE10
  wire [63:0] leftExt = 64'(leftUpProd) + 64'(leftDnProd); // RULE3
  wire [63:0] rightExt = 64'(rightUpProd) + 64'(rightDnProd); // RULE3
  // Select the dot-product term for the operation.
  assign dotSum = (op == OP_LEFT_BYTE) ? leftExt :
                  (op == OP_RIGHT_BYTE) ? rightExt :
                  (op == OP_CROSS) ? 64'(crossSum) : // RULE8
                  (op == OP_SUBTRACT) ? 64'(straightSum) : 64'h0; // RULE10
  assign subtract = (op == OP_SUBTRACT);
endmodule : dot_acc_products

// File: verif/pipe_model.sv
// Pipeline model that issues instructions to the dot-product unit.
`timescale 1ns/10ps
module pipe_model (
  input wire logic core_clk,
  output logic issueValid,
  output dot_acc_pkg::issue_s issue,
  output logic extPresent,
  output logic extEnabled,
  output logic [3:0] ovfFlagsIn
);
  import dot_acc_pkg::*;
  // The pipeline stays idle until the first request.
  initial begin
    issueValid = 1'b0;
    issue = '0;
    extPresent = 1'b1;
    extEnabled = 1'b1;
    ovfFlagsIn = 4'h0;
  end
  // Presents one instruction after a rising edge.
  task automatic send(input logic [31:0] word, input logic [31:0] a, input logic [31:0] b,
      input logic pres, input logic en, input logic [3:0] flags);
    @(posedge core_clk);
    issueValid <= 1'b1;
    issue <= '{word, a, b};
    extPresent <= pres;
    extEnabled <= en;
    ovfFlagsIn <= flags;
  endtask : send
  // Drops the request at the taking edge; stale operands are inverted so no echo survives.
  task automatic retire();
    @(posedge core_clk);
    issueValid <= 1'b0;
    issue <= ~issue;
  endtask : retire
endmodule : pipe_model

// File: verif/dot_product_accumulate_unit_tb.sv
// Self-checking bench for the dot-product accumulate unit.
`timescale 1ns/10ps
`include "dot_acc_params.svh"
module dot_product_accumulate_unit_tb;
  import dot_acc_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] readSel = 2'h0;
  logic issueValid, extPresent, extEnabled, reservedExc, disabledExc, dataExc, accepted;
  logic [3:0] ovfFlagsIn, ovfFlags;
  logic [31:0] upperWordHalf, bottomWordHalf;
  issue_s issue;
  integer seed = 32'h39AE52DC;
  int n_errors = 0;
  int comparisons = 0;
  logic [63:0] model [4] = '{default: 64'h0}; // Reference accumulators.
  logic [4:0] subops [4] = '{`SUBOP_LEFT_BYTE, `SUBOP_RIGHT_BYTE, `SUBOP_CROSS, `SUBOP_SUBTRACT};
  // Clock at 125 MHz.
  always #4 core_clk = ~core_clk;
  pipe_model pl (.core_clk(core_clk), .issueValid(issueValid), .issue(issue),
    .extPresent(extPresent), .extEnabled(extEnabled), .ovfFlagsIn(ovfFlagsIn));
  dot_product_accumulate_unit uut (.core_clk(core_clk), .sys_rst(sys_rst),
    .issueValid(issueValid), .issue(issue), .extPresent(extPresent), .extEnabled(extEnabled),
    .ovfFlagsIn(ovfFlagsIn), .ovfFlags(ovfFlags), .reservedExc(reservedExc),
    .disabledExc(disabledExc), .dataExc(dataExc), .accepted(accepted),
    .upperWordHalf(upperWordHalf), .bottomWordHalf(bottomWordHalf), .readSel(readSel));
  // Case inequality lets an unknown count as a mismatch.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Reference dot product; halfword products are widened before the sum to keep bit 32.
  function automatic logic [63:0] dot(input logic [4:0] sub, input logic [31:0] a,
      input logic [31:0] b);
    longint p;
    longint q;
    if (sub == `SUBOP_LEFT_BYTE) return a[31:24] * b[31:24] + a[23:16] * b[23:16];
    if (sub == `SUBOP_RIGHT_BYTE) return a[15:8] * b[15:8] + a[7:0] * b[7:0];
    p = $signed(a[31:16]);
    q = $signed(a[15:0]);
    p = p * longint'($signed(sub == `SUBOP_CROSS ? b[15:0] : b[31:16]));
    q = q * longint'($signed(sub == `SUBOP_CROSS ? b[31:16] : b[15:0]));
    return p + q;
  endfunction : dot
  // One instruction from issue to readback of its accumulator.
  task automatic run_op(input logic [4:0] sub, input logic [5:0] func, input logic [1:0] sel,
      input logic [31:0] a, input logic [31:0] b, input logic pres, input logic en);
    logic grp;
    logic [3:0] flags;
    logic [63:0] d;
    grp = (func == `DOT_FUNC_CLASS) && (sub inside {subops});
    flags = $random(seed);
    pl.send({`EXT_MAJOR_OPCODE, 10'h000, 3'h0, sel, sub, func}, a, b, pres, en, flags);
    #1 check(accepted, grp & pres & en);
    d = dot(sub, a, b);
    // Only a taken instruction moves the reference.
    if (grp && pres && en) begin
      model[sel] = (sub == `SUBOP_SUBTRACT) ? model[sel] - d : model[sel] + d;
    end
    pl.retire();
    readSel <= sel;
    #1 check(reservedExc, grp & ~pres);
    check(disabledExc, grp & pres & ~en);
    check(ovfFlags, flags);
    check(dataExc, 1'b0);
    @(posedge core_clk);
    #1 check({upperWordHalf, bottomWordHalf}, model[sel]);
  endtask : run_op
  // Prints counts and the verdict, then stops.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // Guards against a hang of the main sequence.
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  // Main sequence.
  initial begin
    logic [31:0] r;
    logic [31:0] o;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk);
      readSel <= s[1:0];
      @(posedge core_clk);
      #1 check({upperWordHalf, bottomWordHalf}, 64'h0);
    end
    $display("reset test done");
    // Extreme operands: full bytes and the most negative halfwords.
    for (int i = 0; i < 4; i++) begin
      o = (i < 2) ? 32'hFFFFFFFF : 32'h80008000;
      run_op(subops[i], `DOT_FUNC_CLASS, i[1:0], o, o, 1'b1, 1'b1);
    end
    $display("boundary test done");
    repeat (40) begin
      r = $random(seed);
      run_op(subops[r[1:0]], `DOT_FUNC_CLASS, r[3:2], $random(seed), $random(seed), 1'b1, 1'b1);
    end
    $display("random test done");
    // Refusals: absent, absent and off, disabled, foreign class, foreign sub-op.
    r = $random(seed);
    run_op(subops[r[1:0]], `DOT_FUNC_CLASS, r[3:2], r, ~r, 1'b0, 1'b1);
    run_op(subops[r[3:2]], `DOT_FUNC_CLASS, r[1:0], r, r, 1'b0, 1'b0);
    run_op(subops[r[5:4]], `DOT_FUNC_CLASS, r[5:4], ~r, r, 1'b1, 1'b0);
    run_op(`SUBOP_CROSS, `DOT_FUNC_CLASS ^ 6'h01, r[7:6], r, r, 1'b1, 1'b1);
    run_op(5'h1F, `DOT_FUNC_CLASS, r[9:8], r, r, 1'b1, 1'b1);
    $display("refusal test done");
    complete_run();
  end
endmodule : dot_product_accumulate_unit_tb
